/* File: core/aotp_pkg.sv */
// constants and carrier types for the output test-pattern and tag-bit inserter
package aotp_pkg;
	// ----------------------------------------
	// register offsets (16-bit word registers)
	// ----------------------------------------
	localparam logic [7:0] ADDR_A_CTRL = 8'h13; // group 1-4 pattern control
	localparam logic [7:0] ADDR_A_P0_LO = 8'h14; // group 1-4 pattern 0 low word
	localparam logic [7:0] ADDR_A_MIX = 8'h15; // group_a_pattern1_low_pattern0_high
	localparam logic [7:0] ADDR_A_P1_HI = 8'h16; // group_a_pattern1_high_word
	localparam logic [7:0] ADDR_B_CTRL = 8'h18; // group_b_pattern_control
	localparam logic [7:0] ADDR_B_P0_LO = 8'h19; // group_b_pattern0_low_word
	localparam logic [7:0] ADDR_B_MIX = 8'h1A; // group_b_pattern1_low_pattern0_high
	localparam logic [7:0] ADDR_B_P1_HI = 8'h1B; // group_b_pattern1_high_word
	localparam logic [7:0] ADDR_TAGS = 8'h1C; // appended_user_bits
	localparam logic [15:0] REG_RESET = 16'h0000; // every register resets to zero
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int EN_BIT = 1; // pattern enable
	localparam int MODE_LSB = 2; // pattern select
	localparam int MODE_MSB = 3;
	localparam int INC_LSB = 4; // ramp increment N
	localparam int INC_MSB = 7;
	localparam int MIX_HI_LSB = 8; // pattern 1 low byte in the mixed word
	localparam int MIX_HI_MSB = 15;
	localparam int MIX_LO_MSB = 7; // pattern 0 high byte in the mixed word
	localparam int TAG_A_LSB = 0; // tag bits for channels 1-4
	localparam int TAG_A_MSB = 5;
	localparam int TAG_B_LSB = 8; // tag bits for channels 5-8
	localparam int TAG_B_MSB = 13;
	// ----------------------------------------
	// pattern select codes and widths
	// ----------------------------------------
	localparam logic [1:0] MODE_RAMP = 2'h2; // digital ramp
	localparam logic [1:0] MODE_ALT = 2'h3; // alternate pattern 0 / 1
	localparam int PAT_W = 24; // test pattern width
	localparam int RES_W = 18; // conversion result width
	localparam int TAG_W = 6; // appended tag width
	localparam int CH_W = 3; // channel index, 0..7 for channels 1..8
	localparam logic [CH_W-1:0] FIRST_B_CH = 3'h4; // index of channel 5
	localparam logic [PAT_W-1:0] RAMP_STEP_ONE = 24'h000001; // the +1 of N+1
	localparam int FIFO_DEPTH = 32; // output buffer depth
	localparam int FIFO_MARGIN = 2; // free slots kept for the stage in flight

	// sample from the converter
	typedef struct packed {
		logic [CH_W-1:0] chan; // channel index
		logic [RES_W-1:0] result; // conversion result
	} aotp_smp_s;

	// word delivered to the host
	typedef struct packed {
		logic [CH_W-1:0] chan; // channel index
		logic [PAT_W-1:0] data; // result or test pattern
		logic [TAG_W-1:0] tag; // appended tag bits
	} aotp_word_s;
endpackage : aotp_pkg

/* File: core/aotp_top.sv */
// test-pattern substitution, tag-bit insertion and output buffer
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// output buffer
// ----------------------------------------
module aotp_fifo #(
	parameter int W = 8, // word width
	parameter int DEPTH = 32 // word count
) (
	input wire logic i_clock, // clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_valid, // write request
	output logic o_ready, // not full
	input wire logic [W-1:0] i_data, // write word
	output logic o_valid, // not empty
	input wire logic i_ready, // read accept
	output logic [W-1:0] o_data, // head word
	output logic [$clog2(DEPTH):0] o_level // words held
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH]; // storage
	logic [AW-1:0] wp_r; // write pointer
	logic [AW-1:0] rp_r; // read pointer
	logic [AW:0] cnt_r; // fill level
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;

	assign o_ready = (cnt_r != (AW+1)'(DEPTH));
	assign o_valid = (cnt_r != '0);
	assign o_data = mem[rp_r];
	assign o_level = cnt_r;

	// storage has no reset, only pointers and fill level do
	always_ff @(posedge i_clock)
	begin
		if (push)
			mem[wp_r] <= i_data;
	end

	// pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : aotp_fifo

module aotp_top #(
	parameter int DEPTH = aotp_pkg::FIFO_DEPTH // output buffer depth
) (
	input wire logic i_clock, // 100 MHz clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic [7:0] i_addr, // register offset
	input wire logic [15:0] i_wdata, // register write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [15:0] o_rdata, // read data, cycle after i_rd
	input wire logic i_in_valid, // converter sample valid
	input wire aotp_pkg::aotp_smp_s i_in, // converter sample
	output logic o_in_ready, // sample may be offered
	output logic o_out_valid, // host word valid
	output aotp_pkg::aotp_word_s o_out, // host word
	input wire logic i_out_ready // host takes the word
);
	// ----------------------------------------
	// register file, index 0 = group A, 1 = group B
	// ----------------------------------------
	logic [15:0] ctl_r [2]; // pattern control
	logic [15:0] p0lo_r [2]; // pattern 0 low word
	logic [15:0] mix_r [2]; // pattern 1 low byte, pattern 0 high byte
	logic [15:0] p1hi_r [2]; // pattern 1 high word
	logic [15:0] tags_r; // appended tag bits
	logic [15:0] rdata_r; // read data
	logic [15:0] rdata_nxt;

	// reserved bits are stored as written: software keeps them at reset
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			for (int g = 0; g < 2; g++)
			begin
				ctl_r[g] <= aotp_pkg::REG_RESET;
				p0lo_r[g] <= aotp_pkg::REG_RESET;
				mix_r[g] <= aotp_pkg::REG_RESET;
				p1hi_r[g] <= aotp_pkg::REG_RESET;
			end
			tags_r <= aotp_pkg::REG_RESET;
		end
		else if (i_wr)
		begin
			unique case (i_addr)
				aotp_pkg::ADDR_A_CTRL: ctl_r[0] <= i_wdata;
				aotp_pkg::ADDR_A_P0_LO: p0lo_r[0] <= i_wdata;
				aotp_pkg::ADDR_A_MIX: mix_r[0] <= i_wdata;
				aotp_pkg::ADDR_A_P1_HI: p1hi_r[0] <= i_wdata;
				aotp_pkg::ADDR_B_CTRL: ctl_r[1] <= i_wdata;
				aotp_pkg::ADDR_B_P0_LO: p0lo_r[1] <= i_wdata;
				aotp_pkg::ADDR_B_MIX: mix_r[1] <= i_wdata;
				aotp_pkg::ADDR_B_P1_HI: p1hi_r[1] <= i_wdata;
				aotp_pkg::ADDR_TAGS: tags_r <= i_wdata;
				default: ; // unmapped writes are dropped
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		unique case (i_addr)
			aotp_pkg::ADDR_A_CTRL: rdata_nxt = ctl_r[0];
			aotp_pkg::ADDR_A_P0_LO: rdata_nxt = p0lo_r[0];
			aotp_pkg::ADDR_A_MIX: rdata_nxt = mix_r[0];
			aotp_pkg::ADDR_A_P1_HI: rdata_nxt = p1hi_r[0];
			aotp_pkg::ADDR_B_CTRL: rdata_nxt = ctl_r[1];
			aotp_pkg::ADDR_B_P0_LO: rdata_nxt = p0lo_r[1];
			aotp_pkg::ADDR_B_MIX: rdata_nxt = mix_r[1];
			aotp_pkg::ADDR_B_P1_HI: rdata_nxt = p1hi_r[1];
			aotp_pkg::ADDR_TAGS: rdata_nxt = tags_r;
			default: rdata_nxt = 16'h0000;
		endcase
	end

	// read data stands for the one cycle after the strobe, zero otherwise
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			rdata_r <= 16'h0000;
		else
			rdata_r <= i_rd ? rdata_nxt : 16'h0000;
	end
	assign o_rdata = rdata_r;

	// ----------------------------------------
	// per-group field decode
	// ----------------------------------------
	logic en [2]; // pattern enable
	logic [1:0] mode [2]; // pattern select
	logic [23:0] inc [2]; // ramp step N+1
	logic [23:0] pat0 [2]; // fixed pattern 0
	logic [23:0] pat1 [2]; // fixed pattern 1
	logic [5:0] tag [2]; // appended tag bits
	logic [23:0] ramp_r [2]; // ramp value for next sample
	logic alt_r [2]; // alternate phase, 0 = pattern 0

	assign en[0] = ctl_r[0][aotp_pkg::EN_BIT];
	assign en[1] = ctl_r[1][aotp_pkg::EN_BIT];
	assign mode[0] = ctl_r[0][aotp_pkg::MODE_MSB:aotp_pkg::MODE_LSB];
	assign mode[1] = ctl_r[1][aotp_pkg::MODE_MSB:aotp_pkg::MODE_LSB];
	assign inc[0] = 24'(ctl_r[0][aotp_pkg::INC_MSB:aotp_pkg::INC_LSB])
		+ aotp_pkg::RAMP_STEP_ONE;
	assign inc[1] = 24'(ctl_r[1][aotp_pkg::INC_MSB:aotp_pkg::INC_LSB])
		+ aotp_pkg::RAMP_STEP_ONE;
	assign pat0[0] = {mix_r[0][aotp_pkg::MIX_LO_MSB:0], p0lo_r[0]};
	assign pat1[0] = {p1hi_r[0], mix_r[0][aotp_pkg::MIX_HI_MSB:aotp_pkg::MIX_HI_LSB]};
	assign pat0[1] = {mix_r[1][aotp_pkg::MIX_LO_MSB:0], p0lo_r[1]};
	assign pat1[1] = {p1hi_r[1], mix_r[1][aotp_pkg::MIX_HI_MSB:aotp_pkg::MIX_HI_LSB]};
	assign tag[0] = tags_r[aotp_pkg::TAG_A_MSB:aotp_pkg::TAG_A_LSB];
	assign tag[1] = tags_r[aotp_pkg::TAG_B_MSB:aotp_pkg::TAG_B_LSB];

	// ----------------------------------------
	// substitution stage
	// ----------------------------------------
	logic in_ready_r; // registered admission
	logic st_valid_r; // stage holds a word
	aotp_pkg::aotp_word_s st_r; // stage word
	aotp_pkg::aotp_word_s st_nxt;
	logic [$clog2(DEPTH):0] level; // buffer fill
	logic fifo_in_ready; // buffer not full
	logic fifo_out_valid; // buffer not empty
	aotp_pkg::aotp_word_s fifo_out; // buffer head
	logic out_valid_r; // host word valid
	aotp_pkg::aotp_word_s out_r; // host word
	wire fifo_pop = fifo_out_valid && (!out_valid_r || i_out_ready); // head moves to output
	wire accept = i_in_valid && in_ready_r;
	wire grp = (i_in.chan >= aotp_pkg::FIRST_B_CH); // 1 = channels 5-8
	wire [23:0] pattern = (mode[grp] == aotp_pkg::MODE_RAMP) ? ramp_r[grp] :
		(mode[grp] == aotp_pkg::MODE_ALT && alt_r[grp]) ? pat1[grp] : pat0[grp];

	// pattern replaces the result only while the group is enabled
	always_comb
	begin
		st_nxt.chan = i_in.chan;
		st_nxt.data = en[grp] ? pattern : 24'(i_in.result);
		st_nxt.tag = tag[grp];
	end

	// ramp and alternate phase advance per sample of their group; both rest at zero
	// while the group is disabled so an enable always starts from a known point
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			ramp_r[0] <= '0;
			ramp_r[1] <= '0;
			alt_r[0] <= 1'b0;
			alt_r[1] <= 1'b0;
		end
		else
		begin
			for (int g = 0; g < 2; g++)
			begin
				if (!en[g])
				begin
					ramp_r[g] <= '0;
					alt_r[g] <= 1'b0;
				end
				else if (accept && grp == g[0])
				begin
					ramp_r[g] <= ramp_r[g] + inc[g];
					alt_r[g] <= !alt_r[g];
				end
			end
		end
	end

	// admission is registered, so it keeps a margin of free slots for the word in
	// flight; under steady back-pressure the words in flight still fill the buffer to all DEPTH words
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			in_ready_r <= 1'b0;
			st_valid_r <= 1'b0;
			st_r <= '0;
		end
		else
		begin
			in_ready_r <= (level < ($clog2(DEPTH)+1)'(DEPTH - aotp_pkg::FIFO_MARGIN));
			st_valid_r <= accept;
			if (accept)
				st_r <= st_nxt;
		end
	end
	assign o_in_ready = in_ready_r;

	aotp_fifo #(
		.W($bits(aotp_pkg::aotp_word_s)),
		.DEPTH(DEPTH)
	) u_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_valid(st_valid_r),
		.o_ready(fifo_in_ready),
		.i_data(st_r),
		.o_valid(fifo_out_valid),
		.i_ready(fifo_pop),
		.o_data(fifo_out),
		.o_level(level)
	);

	// ----------------------------------------
	// output register
	// ----------------------------------------
	// word stands until the host takes it
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			out_valid_r <= 1'b0;
			out_r <= '0;
		end
		else
		begin
			out_valid_r <= fifo_pop || (out_valid_r && !i_out_ready);
			if (fifo_pop)
				out_r <= fifo_out;
		end
	end
	assign o_out_valid = out_valid_r;
	assign o_out = out_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	a_b_passthru: assert property (accept && grp && !en[1] |=>
		st_r.data == 24'($past(i_in.result)))
		else $error("group B result not passed through");
	a_b_fixed0: assert property (accept && grp && en[1] && mode[1] < aotp_pkg::MODE_RAMP |=>
		st_r.data == {$past(mix_r[1][7:0]), $past(p0lo_r[1])})
		else $error("group B fixed pattern 0 wrong");
	a_b_alt_pair: assert property (accept && grp && en[1]
		&& mode[1] == aotp_pkg::MODE_ALT && alt_r[1]
		|=> st_r.data == {$past(p1hi_r[1]), $past(mix_r[1][15:8])})
		else $error("group B pattern 1 wrong");
	a_a_alt_pair: assert property (accept && !grp && en[0]
		&& mode[0] == aotp_pkg::MODE_ALT && alt_r[0]
		|=> st_r.data == {$past(p1hi_r[0]), $past(mix_r[0][15:8])})
		else $error("group A pattern 1 wrong");
	a_a_fixed0_hi: assert property (accept && !grp && en[0]
		&& mode[0] != aotp_pkg::MODE_RAMP && !alt_r[0]
		|=> st_r.data[23:16] == $past(mix_r[0][7:0]))
		else $error("group A pattern 0 high byte wrong");
	a_tag_b: assert property (accept && grp |=> st_r.tag == $past(tags_r[13:8]))
		else $error("group B tag bits wrong");
	a_tag_a: assert property (accept && !grp |=> st_r.tag == $past(tags_r[5:0]))
		else $error("group A tag bits wrong");
	a_ramp_step: assert property (accept && grp && en[1]
		&& mode[1] == aotp_pkg::MODE_RAMP && $stable(ctl_r[1])
		|=> ramp_r[1] == 24'($past(ramp_r[1])
		+ 24'($past(ctl_r[1][aotp_pkg::INC_MSB:aotp_pkg::INC_LSB]))
		+ aotp_pkg::RAMP_STEP_ONE))
		else $error("ramp step not N+1");
	a_a_enable: assert property (accept && !grp && !en[0] |=>
		st_r.data == 24'($past(i_in.result)))
		else $error("group A result not passed through");
	a_alt_toggle: assert property (accept && grp && en[1] ##1 en[1] |->
		alt_r[1] != $past(alt_r[1]))
		else $error("alternate phase did not toggle");
	a_ramp_rest: assert property (!en[1] |=> ramp_r[1] == 24'h000000 && !alt_r[1])
		else $error("ramp not restarted while disabled");
	a_no_overflow: assert property (st_valid_r |-> fifo_in_ready)
		else $error("buffer overflow");
	a_read_once: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data outside its cycle");

	c_ramp: cover property (accept && grp && en[1] && mode[1] == aotp_pkg::MODE_RAMP
		##1 accept && grp);
	c_alt: cover property (accept && !grp && en[0] && mode[0] == aotp_pkg::MODE_ALT
		##1 accept && !grp);
	c_full: cover property (!fifo_in_ready);
	c_stall: cover property (out_valid_r && !i_out_ready ##1 out_valid_r && i_out_ready);
endmodule : aotp_top

`default_nettype wire

/* File: verif/aotp_host.sv */
// host controller model that takes finished words from the output buffer
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// host sink
// ----------------------------------------
module aotp_host (
	input wire logic i_clock, // clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_valid, // word offered
	input wire aotp_pkg::aotp_word_s i_word, // offered word
	input wire logic i_hold, // stop taking words; the device still accepts samples until its buffer is full
	input wire logic i_slow, // take a word only every other cycle
	output logic o_ready // host takes the word
);
	aotp_pkg::aotp_word_s got[$]; // words received, oldest first

	// ready is registered, so a stall only lands one cycle after it is asked for
	always @(posedge i_clock)
	begin
		if (!i_rst_n)
			o_ready <= 1'b0;
		else
			o_ready <= !i_hold && (!i_slow || !o_ready);
		// a word counts only where valid and ready meet at the edge
		if (i_rst_n && i_valid && o_ready)
			got.push_back(i_word);
	end
endmodule : aotp_host

`default_nettype wire

/* File: verif/aotp_top_bench.sv */
// self-checking bench for the test-pattern and tag-bit inserter
`timescale 1ns/10ps
`default_nettype none

module aotp_top_bench;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic i_clock = 1'b0; // 100 MHz
	logic i_rst_n = 1'b0; // reset, active low
	logic [7:0] i_addr = 8'h00; // register offset
	logic [15:0] i_wdata = 16'h0000; // write data
	logic i_wr = 1'b0; // write strobe
	logic i_rd = 1'b0; // read strobe
	logic [15:0] o_rdata; // read data
	logic i_in_valid = 1'b0; // sample offered
	aotp_pkg::aotp_smp_s i_in = '0; // sample
	logic o_in_ready; // sample may be offered
	logic o_out_valid; // word offered
	aotp_pkg::aotp_word_s o_out; // word
	logic i_out_ready; // host ready
	logic i_hold = 1'b0; // host stall
	logic i_slow = 1'b0; // host slow
	int errors = 0; // mismatches
	int n_checks = 0; // comparisons
	int n; // accepted sample count
	logic [7:0] ra [8] = '{8'h14, 8'h15, 8'h16, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h20};
	// reserved bits of the tag word stay zero; the unmapped place reads zero
	logic [15:0] rv [8] = '{16'h3210, 16'h7654, 16'h9A98, 16'hCDEF, 16'h56AB, 16'h1234,
		16'h2A15, 16'h0000};
	logic [23:0] ea; // expected group 1-4 data
	logic [23:0] eb; // expected group 5-8 data

	aotp_top i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_in_valid(i_in_valid), .i_in(i_in),
		.o_in_ready(o_in_ready), .o_out_valid(o_out_valid), .o_out(o_out),
		.i_out_ready(i_out_ready));
	aotp_host i_host (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_valid(o_out_valid),
		.i_word(o_out), .i_hold(i_hold), .i_slow(i_slow), .o_ready(i_out_ready));

	// clock generator
	initial
	begin
		forever #5 i_clock = ~i_clock;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH t=%0t read %h expected %h", $time, g, e);
		end
	endtask : chk16

	// two cycles per write, so strobes never get two values in one step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		@(posedge i_clock);
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		chk16(o_rdata, e);
		@(posedge i_clock);
	endtask : rd

	// leaves valid high so that samples go back to back
	task automatic send(input logic [2:0] c, input logic [17:0] r);
		i_in_valid <= 1'b1;
		i_in <= '{chan: c, result: r};
		do @(negedge i_clock); while (o_in_ready !== 1'b1);
		@(posedge i_clock);
	endtask : send

	// waits a bounded time for the host to receive the next word
	task automatic chkw(input logic [2:0] c, input logic [23:0] d, input logic [5:0] t);
		aotp_pkg::aotp_word_s e;
		aotp_pkg::aotp_word_s w;
		e = '{chan: c, data: d, tag: t};
		w = '1;
		for (int i = 0; i < 300 && i_host.got.size() == 0; i++)
			@(posedge i_clock);
		if (i_host.got.size() > 0)
			w = i_host.got.pop_front();
		n_checks++;
		if (w !== e)
		begin
			errors++;
			$display("MISMATCH t=%0t word %h expected %h", $time, w, e);
		end
	endtask : chkw

	// ----------------------------------------
	// watchdog: the whole sequence needs well under 5000 cycles
	// ----------------------------------------
	initial
	begin
		repeat (20000) @(posedge i_clock);
		errors++;
		end_sim();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		// every register resets to zero
		for (int i = 0; i < 8; i++)
			rd(ra[i], 16'h0000);
		rd(8'h13, 16'h0000);
		rd(8'h18, 16'h0000);
		// patterns and tags, then an unmapped write that must vanish
		for (int i = 0; i < 8; i++)
			wr(ra[i], (i == 7) ? 16'hFFFF : rv[i]);
		for (int i = 0; i < 8; i++)
			rd(ra[i], rv[i]);
		// results pass untouched with group tags; full-scale and tiny values
		send(3'h0, 18'h3FFFF);
		send(3'h7, 18'h00001);
		i_in_valid <= 1'b0;
		chkw(3'h0, 24'h03FFFF, 6'h15);
		chkw(3'h7, 24'h000001, 6'h2A);
		// every pattern select code, both groups interleaved, different steps
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h13, 16'(32'h32 | (m << 2)));
			wr(8'h18, 16'(32'h02 | (m << 2)));
			rd(8'h18, 16'(32'h02 | (m << 2)));
			for (int k = 0; k < 4; k++)
			begin
				send(3'(k), 18'h00000);
				send(3'(k + 4), 18'h3FFFF);
			end
			i_in_valid <= 1'b0;
			for (int k = 0; k < 4; k++)
			begin
				ea = (m == 2) ? 24'(k * 4) : (m == 3 && k % 2 == 1) ? 24'h9A9876 : 24'h543210;
				eb = (m == 2) ? 24'(k) : (m == 3 && k % 2 == 1) ? 24'h123456 : 24'hABCDEF;
				chkw(3'(k), ea, 6'h15);
				chkw(3'(k + 4), eb, 6'h2A);
			end
			// disabling returns ramp and alternation to their start
			wr(8'h13, 16'h0000);
			wr(8'h18, 16'h0000);
		end
		// fill the buffer against a stalled host until it refuses
		i_hold <= 1'b1;
		n = 0;
		i_in_valid <= 1'b1;
		while (n < 64)
		begin
			i_in <= '{chan: 3'(n), result: 18'(n)};
			@(negedge i_clock);
			if (o_in_ready !== 1'b1)
				break;
			@(posedge i_clock);
			n++;
		end
		@(posedge i_clock);
		i_in_valid <= 1'b0;
		chk16(16'(n >= 30 && n <= 34), 16'h0001);
		// drain slowly until empty, order preserved
		i_hold <= 1'b0;
		i_slow <= 1'b1;
		for (int k = 0; k < n; k++)
			chkw(3'(k), 24'(k), (k % 8 < 4) ? 6'h15 : 6'h2A);
		chk16(16'(i_host.got.size()), 16'h0000);
		end_sim();
	end
endmodule : aotp_top_bench

`default_nettype wire
